// ---- design/comparator_input_select.sv ----
// What this block does
// - with mux enable set and converter off, the channel field picks the positive input.
// - with mux enable clear or converter on, the dedicated positive pin is used.
// - channel codes 0 through 10 pick analog channels 0 through 10, code 3 shared with the current source.
// - with internal reference select clear, the dedicated negative pin is used.
// - with internal reference select set, the reference field picks the internal level on the negative input; codes 00 and 10 connect none.
// - reference field 01 gives the 1.1 V reference regardless of the divider.
// - reference field 11 with divider 00..11 gives 2.56 V scaled by 1, 1/2, 1/4, 1/8.
// - mux enable is bit 6 of control register b, reset zero, read/write.
// - divider select is bits 5:4 of control register b, effective only with reference select set.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
module comparator_input_select (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic pos_pin_sel,
  output logic [10:0] pos_channel_sel,
  output logic pos_current_source,
  output logic neg_pin_sel,
  output logic neg_ref_1v1_sel,
  output logic neg_ref_2v56_sel,
  output logic [1:0] neg_divider
);

  // ============================================================
  // state
  typedef struct packed {
    logic [7:0] control_b;
    logic [7:0] channel;
    logic [7:0] control_a;
    logic [7:0] comp_status;
    logic [7:0] rdata;
    cmp_sel_pkg::pos_src_t pos_src;
    logic [10:0] pos_onehot;
    logic pos_current_source_output;
    cmp_sel_pkg::neg_src_t neg_src;
    logic [1:0] div;
    logic pos_pin;
    logic neg_pin;
    logic neg_1v1;
    logic neg_2v56;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic mux_en;
  logic conv_en;
  logic iref_sel;
  logic [4:0] chan;
  logic [1:0] refsrc;
  logic [1:0] divsel;

  // current control fields
  assign mux_en = s_q.control_b[cmp_sel_pkg::MUX_EN_BIT];
  assign divsel = s_q.control_b[cmp_sel_pkg::DIV_LO_BIT +: 2];
  assign conv_en = s_q.control_a[cmp_sel_pkg::CONV_EN_BIT];
  assign refsrc = s_q.channel[cmp_sel_pkg::REFSRC_LO_BIT +: 2];
  assign chan = s_q.channel[4:0];
  assign iref_sel = s_q.comp_status[cmp_sel_pkg::IREF_SEL_BIT];

  // ============================================================
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // register writes, only writable bits kept
    if (reg_write)
    begin
      unique case (reg_addr)
        cmp_sel_pkg::OFF_CONTROL_B: s_d.control_b = reg_wdata & cmp_sel_pkg::CONTROL_B_MASK;
        cmp_sel_pkg::OFF_CHANNEL: s_d.channel = reg_wdata & cmp_sel_pkg::CHANNEL_MASK;
        cmp_sel_pkg::OFF_CONTROL_A: s_d.control_a = reg_wdata & cmp_sel_pkg::CONTROL_A_MASK;
        cmp_sel_pkg::OFF_COMP_STATUS: s_d.comp_status = reg_wdata & cmp_sel_pkg::COMP_STATUS_MASK;
        default: s_d.rdata = 8'h00; // unmapped writes ignored
      endcase
    end
    // reads answer one cycle later, unmapped reads give zero
    if (reg_read)
    begin
      unique case (reg_addr)
        cmp_sel_pkg::OFF_CONTROL_B: s_d.rdata = s_q.control_b;
        cmp_sel_pkg::OFF_CHANNEL: s_d.rdata = s_q.channel;
        cmp_sel_pkg::OFF_CONTROL_A: s_d.rdata = s_q.control_a;
        cmp_sel_pkg::OFF_COMP_STATUS: s_d.rdata = s_q.comp_status;
        cmp_sel_pkg::OFF_SELECT_STATUS: s_d.rdata = {2'b00, s_q.neg_src, 2'b00, s_q.pos_src};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // positive input decode from the current bits
    s_d.pos_onehot = 11'h000;
    s_d.pos_current_source_output = 1'b0;
    if (mux_en && !conv_en)
    begin
      if (chan <= cmp_sel_pkg::CHANNEL_LAST)
      begin
        s_d.pos_src = cmp_sel_pkg::POS_CHANNEL;
        s_d.pos_onehot = 11'h001 << chan;
        s_d.pos_current_source_output = (chan == cmp_sel_pkg::CHANNEL_CURRENT_SOURCE_OUTPUT);
      end
      else
      begin
        // undefined codes connect nothing rather than guess a source
        s_d.pos_src = cmp_sel_pkg::POS_UNDEFINED;
      end
    end
    else
    begin
      s_d.pos_src = cmp_sel_pkg::POS_PIN;
    end
    // negative input decode
    s_d.div = 2'b00;
    if (!iref_sel)
    begin
      s_d.neg_src = cmp_sel_pkg::NEG_PIN;
    end
    else if (refsrc == cmp_sel_pkg::REFSRC_1V1)
    begin
      s_d.neg_src = cmp_sel_pkg::NEG_REF_1V1;
    end
    else if (refsrc == cmp_sel_pkg::REFSRC_2V56)
    begin
      s_d.neg_src = cmp_sel_pkg::NEG_REF_2V56;
      s_d.div = divsel;
    end
    else
    begin
      // other reference codes have no defined comparator level
      s_d.neg_src = cmp_sel_pkg::NEG_UNDEFINED;
    end
    // one flag per source, so each select output leaves its own flip-flop
    s_d.pos_pin = (s_d.pos_src == cmp_sel_pkg::POS_PIN);
    s_d.neg_pin = (s_d.neg_src == cmp_sel_pkg::NEG_PIN);
    s_d.neg_1v1 = (s_d.neg_src == cmp_sel_pkg::NEG_REF_1V1);
    s_d.neg_2v56 = (s_d.neg_src == cmp_sel_pkg::NEG_REF_2V56);
  end

  // ============================================================
  // registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q.control_b <= cmp_sel_pkg::CONTROL_B_RESET;
      s_q.channel <= cmp_sel_pkg::CHANNEL_RESET;
      s_q.control_a <= cmp_sel_pkg::CONTROL_A_RESET;
      s_q.comp_status <= cmp_sel_pkg::COMP_STATUS_RESET;
      s_q.rdata <= 8'h00;
      s_q.pos_src <= cmp_sel_pkg::POS_PIN;
      s_q.pos_onehot <= 11'h000;
      s_q.pos_current_source_output <= 1'b0;
      s_q.neg_src <= cmp_sel_pkg::NEG_PIN;
      s_q.div <= 2'b00;
      s_q.pos_pin <= 1'b1;
      s_q.neg_pin <= 1'b1;
      s_q.neg_1v1 <= 1'b0;
      s_q.neg_2v56 <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // outputs
  // straight from flip-flops, so the analog switches never see a decode glitch
  assign reg_rdata = s_q.rdata;
  assign pos_pin_sel = s_q.pos_pin;
  assign pos_channel_sel = s_q.pos_onehot;
  assign pos_current_source = s_q.pos_current_source_output;
  assign neg_pin_sel = s_q.neg_pin;
  assign neg_ref_1v1_sel = s_q.neg_1v1;
  assign neg_ref_2v56_sel = s_q.neg_2v56;
  assign neg_divider = s_q.div;

  // ============================================================
  // checks
  sequence mux_mode_s;
    mux_en && !conv_en && (chan <= cmp_sel_pkg::CHANNEL_LAST);
  endsequence

  sequence channel_shown_s;
    ##1 !pos_pin_sel && (pos_channel_sel == (11'h001 << $past(chan)));
  endsequence

  mux_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    mux_mode_s |-> channel_shown_s) else $error("channel not routed to positive input");
  pin_positive_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!mux_en || conv_en) |=> pos_pin_sel && (pos_channel_sel == 11'h000)) else $error("positive pin not selected");
  current_source_output_share_a: assert property (@(posedge ref_clk) disable iff (reset)
    pos_current_source |-> pos_channel_sel[3] && !pos_pin_sel) else $error("current source not on channel three");
  pin_negative_a: assert property (@(posedge ref_clk) disable iff (reset)
    !iref_sel |=> neg_pin_sel && !neg_ref_1v1_sel && !neg_ref_2v56_sel) else $error("negative pin not selected");
  ref_onehot_a: assert property (@(posedge ref_clk) disable iff (reset)
    $countones({neg_pin_sel, neg_ref_1v1_sel, neg_ref_2v56_sel}) <= 1) else $error("negative sources overlap");
  ref_1v1_a: assert property (@(posedge ref_clk) disable iff (reset)
    (iref_sel && refsrc == cmp_sel_pkg::REFSRC_1V1) |=> neg_ref_1v1_sel && neg_divider == 2'b00)
    else $error("1.1 V reference not selected");
  ref_2v56_a: assert property (@(posedge ref_clk) disable iff (reset)
    (iref_sel && refsrc == cmp_sel_pkg::REFSRC_2V56) |=> neg_ref_2v56_sel && neg_divider == $past(divsel))
    else $error("2.56 V divider wrong");
  mux_bit_rw_a: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_write && reg_addr == cmp_sel_pkg::OFF_CONTROL_B) ##1 (reg_read && reg_addr == cmp_sel_pkg::OFF_CONTROL_B)
    |=> reg_rdata[6:4] == $past(reg_wdata[6:4], 2)) else $error("control b readback wrong");
  div_gated_a: assert property (@(posedge ref_clk) disable iff (reset)
    !neg_ref_2v56_sel |-> neg_divider == 2'b00) else $error("divider active without 2.56 V reference");
  next_cycle_a: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(mux_en) && !conv_en && chan <= cmp_sel_pkg::CHANNEL_LAST |=> pos_pin_sel == !$past(mux_en))
    else $error("selection did not follow control bit");
  // reference codes without a level must leave every negative source open
  ref_none_a: assert property (@(posedge ref_clk) disable iff (reset)
    (iref_sel && refsrc != cmp_sel_pkg::REFSRC_1V1 && refsrc != cmp_sel_pkg::REFSRC_2V56)
    |=> !neg_pin_sel && !neg_ref_1v1_sel && !neg_ref_2v56_sel)
    else $error("undefined reference drives the negative input");

endmodule

// ---- design/cmp_sel_pkg.sv ----
// ============================================================
// comparator input selection constants
package cmp_sel_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] OFF_CONTROL_B = 4'h0;
  localparam logic [3:0] OFF_CHANNEL = 4'h1;
  localparam logic [3:0] OFF_CONTROL_A = 4'h2;
  localparam logic [3:0] OFF_COMP_STATUS = 4'h3;
  localparam logic [3:0] OFF_SELECT_STATUS = 4'h4;

  // field positions
  localparam int MUX_EN_BIT = 6;
  localparam int DIV_LO_BIT = 4;
  localparam int CONV_EN_BIT = 7;
  localparam int REFSRC_LO_BIT = 6;
  localparam int IREF_SEL_BIT = 6;

  // reset values
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [7:0] COMP_STATUS_RESET = 8'h00;

  // writable bit masks
  localparam logic [7:0] CONTROL_B_MASK = 8'h70;
  localparam logic [7:0] CHANNEL_MASK = 8'hdf;
  localparam logic [7:0] CONTROL_A_MASK = 8'h80;
  localparam logic [7:0] COMP_STATUS_MASK = 8'h40;

  // channel and reference codes
  localparam logic [4:0] CHANNEL_LAST = 5'h0a;
  localparam logic [4:0] CHANNEL_CURRENT_SOURCE_OUTPUT = 5'h03;
  localparam logic [1:0] REFSRC_1V1 = 2'h1;
  localparam logic [1:0] REFSRC_2V56 = 2'h3;

  // positive input source
  typedef enum logic [1:0] {POS_PIN, POS_CHANNEL, POS_UNDEFINED} pos_src_t;
  // negative input source
  typedef enum logic [1:0] {NEG_PIN, NEG_REF_1V1, NEG_REF_2V56, NEG_UNDEFINED} neg_src_t;

endpackage

// ---- verif/analog_sources.sv ----
`timescale 1ns/100ps
// ============================================================
// far side: reference ladder feeding the negative input
module analog_sources (
  input wire logic neg_ref_1v1_sel,
  input wire logic neg_ref_2v56_sel,
  input wire logic [1:0] neg_divider,
  output int neg_mv
);
  // level in millivolts; -1 marks the pin or no internal level
  always_comb
  begin
    if (neg_ref_1v1_sel)
      neg_mv = 32'h0000_044c;
    else if (neg_ref_2v56_sel)
      neg_mv = 32'h0000_0a00 >> neg_divider;
    else
      neg_mv = 32'hffff_ffff;
  end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
module tb;
  // ============================================================
  // signals and bookkeeping
  logic ref_clk, reset, reg_write, reg_read, rd_taken;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic pos_pin_sel, pos_current_source, neg_pin_sel, neg_ref_1v1_sel, neg_ref_2v56_sel;
  logic [10:0] pos_channel_sel;
  logic [1:0] neg_divider;
  logic [7:0] rd_q[$];
  logic [7:0] wdat [4] = '{8'hff, 8'hea, 8'hff, 8'hff};
  logic [7:0] msk [4] = '{cmp_sel_pkg::CONTROL_B_MASK, cmp_sel_pkg::CHANNEL_MASK,
    cmp_sel_pkg::CONTROL_A_MASK, cmp_sel_pkg::COMP_STATUS_MASK};
  int neg_mv, err_count, total_checks;
  comparator_input_select dut_u (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pos_pin_sel(pos_pin_sel), .pos_channel_sel(pos_channel_sel), .pos_current_source(pos_current_source),
    .neg_pin_sel(neg_pin_sel), .neg_ref_1v1_sel(neg_ref_1v1_sel), .neg_ref_2v56_sel(neg_ref_2v56_sel),
    .neg_divider(neg_divider));
  analog_sources src_u (.neg_ref_1v1_sel(neg_ref_1v1_sel), .neg_ref_2v56_sel(neg_ref_2v56_sel),
    .neg_divider(neg_divider), .neg_mv(neg_mv));
  // ============================================================
  // tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // bus tasks start right after a rising edge and return on the edge that takes
  // the strobe, so calls may follow each other with no gap
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    rd_q.push_back(exp);
    @(posedge ref_clk);
  endtask
  task automatic idle();
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  // program every control, then look one edge after the last write
  task automatic sel(input logic mux, conv, iref, input logic [4:0] ch, input logic [1:0] rs, dv);
    logic on;
    logic [1:0] ns;
    on = mux & ~conv;
    ns = iref ? (rs == 2'h1 ? 2'h1 : rs == 2'h3 ? 2'h2 : 2'h3) : 2'h0;
    wr(4'h0, {1'b0, mux, dv, 4'h0});
    wr(4'h1, {rs, 1'b0, ch});
    wr(4'h2, {conv, 7'h00});
    wr(4'h3, {1'b0, iref, 6'h00});
    idle();
    #1;
    check("pos_pin", pos_pin_sel, !on);
    check("pos_chan", pos_channel_sel, on ? 11'h001 << ch : 11'h000);
    check("cur_src", pos_current_source, on && ch == 5'h03);
    check("neg_pin", neg_pin_sel, !iref);
    check("neg_1v1", neg_ref_1v1_sel, ns == 2'h1);
    check("neg_2v56", neg_ref_2v56_sel, ns == 2'h2);
    check("neg_div", neg_divider, ns == 2'h2 ? dv : 2'h0);
    check("neg_mv", neg_mv, ns == 2'h1 ? 32'h0000_044c : ns == 2'h2 ? 32'h0000_0a00 >> dv : 32'hffff_ffff);
    @(posedge ref_clk);
    rd(4'h4, {2'h0, ns, 3'h0, on});
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ============================================================
  // clock, read-data watcher and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk) rd_taken <= reg_read & ~reset;
  always @(negedge ref_clk)
    if (rd_taken && rd_q.size() > 0)
      check("rdata", reg_rdata, rd_q.pop_front());
  // a hung run would otherwise never print a verdict
  initial
  begin
    #20_000;
    err_count++;
    complete_run();
  end
  // ============================================================
  // main sequence
  initial
  begin
    {reset, reg_write, reg_read, reg_addr, reg_wdata} = {1'b1, 14'h0000};
    void'($urandom(70735));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 5; a++) rd(4'(a), 8'h00);
    idle();
    // reset values looked at mid-cycle, away from the launching edge
    @(negedge ref_clk);
    check("pos_pin_rst", pos_pin_sel, 1'b1);
    check("neg_pin_rst", neg_pin_sel, 1'b1);
    @(posedge ref_clk);
    // control register b written first while the channel field still holds code 0, and code 10 follows, so no undefined code shows in mux mode
    for (int a = 0; a < 4; a++)
    begin
      wr(4'(a), wdat[a]);
      rd(4'(a), wdat[a] & msk[a]);
    end
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    for (int c = 0; c <= 10; c++) sel(1'b1, 1'b0, 1'b0, 5'(c), 2'h1, 2'h0);
    sel(1'b1, 1'b1, 1'b0, 5'h05, 2'h1, 2'h2);
    sel(1'b0, 1'b0, 1'b0, 5'h07, 2'h3, 2'h3);
    sel(1'b0, 1'b0, 1'b1, 5'h02, 2'h0, 2'h1);
    for (int d = 0; d < 4; d++)
    begin
      sel(1'b0, 1'b0, 1'b1, 5'h00, 2'h3, 2'(d));
      sel(1'b1, 1'b0, 1'b1, 5'h03, 2'h1, 2'(d));
    end
    repeat (8) sel(1'($urandom), 1'($urandom), 1'($urandom), 5'($urandom % 11),
      $urandom % 2 ? 2'h3 : 2'h1, 2'($urandom));
    idle();
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
endmodule
